// file: common/pin_mux_defines.svh
// Purpose: Named constants of the sensor pin function block.
// Assumes: Included by its bare name wherever a constant is needed.
// Notes:   Definitions only.
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// -----------------------------------------------------------------
// Interface select codes
// -----------------------------------------------------------------
`define MODE_PARALLEL     2'h0
`define MODE_SPI_SLAVE    2'h1
`define MODE_USB_INTERNAL 2'h2
`define MODE_USB_EXTERNAL 2'h3

// -----------------------------------------------------------------
// Counts
// -----------------------------------------------------------------
`define SETTLE_COUNT  2'h3
`define LAST_BIT      3'h7

`endif

// file: common/pin_mux_pkg.sv
// Purpose: Types shared by the sensor pin function modules.
// Assumes: Nothing is imported; users write pin_mux_pkg::name.
// Notes:   Serial ROM sequencer states only.
package pin_mux_pkg;

  typedef enum logic [1:0] {
    ROM_IDLE,
    ROM_SHIFT
  } rom_state_t;

endpackage

// file: common/link_if.sv
// Purpose: Carries received serial bytes from the link clock domain.
// Assumes: rxToggle flips once per byte; rxByte is stable around it.
// Notes:   The core side must synchronise rxToggle before use.
`timescale 1ns/100ps
interface link_if;
  logic [7:0] rxByte;
  logic       rxToggle;

  modport front (output rxByte, output rxToggle);
  modport core  (input rxByte, input rxToggle);
endinterface : link_if

// file: verilog/bit_sync.sv
// Purpose: Two flip-flop synchroniser for a bundle of single-bit levels.
// Assumes: Each bit is an independent level; no word coherence.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  input  logic             clk,
  input  logic             reset,
  input  logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gBit
      always_comb begin
        next_s.stage1[g] = asyncIn[g];
        next_s.stage2[g] = s.stage1[g];
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign syncOut = s.stage2;

endmodule // bit_sync

// file: verilog/serial_link_front.sv
// Purpose: Shifts slave serial input on the master's serial clock.
// Assumes: linkClk runs only inside frames; select high ends a frame.
// Notes:   Bits arrive most significant first, sampled on rising edges.
`timescale 1ns/100ps
`include "pin_mux_defines.svh"
module serial_link_front (
  input  wire logic linkClk,
  input  wire logic reset,
  input  wire logic slaveSelectN,
  input  wire logic serialIn,
  link_if.front     lnk
);

  typedef struct packed {
    logic [2:0] bitCnt;
    logic [6:0] shift;
  } frame_state_t;

  typedef struct packed {
    logic [7:0] rxByte;
    logic       rxToggle;
  } out_state_t;

  frame_state_t f;
  frame_state_t next_f;
  out_state_t   o;
  out_state_t   next_o;

  always_comb begin
    next_f        = f;
    next_o        = o;
    next_f.bitCnt = f.bitCnt + 3'h1;
    next_f.shift  = {f.shift[5:0], serialIn};
    if (f.bitCnt == `LAST_BIT) begin
      next_o.rxByte   = {f.shift, serialIn};
      next_o.rxToggle = ~o.rxToggle;
    end
  end

  // The clock stops between frames, so select high clears a partial byte.
  always_ff @(posedge linkClk or posedge slaveSelectN) begin
    if (slaveSelectN) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end

  // Kept apart from the frame state so a frame end cannot fake an event.
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      o <= '0;
    end else begin
      o <= next_o;
    end
  end

  assign lnk.rxByte   = o.rxByte;
  assign lnk.rxToggle = o.rxToggle;

endmodule // serial_link_front

// file: verilog/sensor_host_pin_function_mux.sv
// Purpose: Pin function selection for the sensor's host-facing pins.
// Assumes: Pins are asynchronous; two-way pins come split in three.
// Notes:   Pin levels on the wire are resolved outside this module.
`timescale 1ns/100ps

// -----------------------------------------------------------------
// Block
// -----------------------------------------------------------------
// What this block does
// - Mode 00: low select selects the chip only while low with high select high.
// - Mode 00: the shared clock/select pin is an active-high chip select.
// - Mode 01: low select is the slave select from the master.
// - Mode 01: the shared clock/select pin is the master's serial clock.
// - Mode 10: both shared select/clock pins are ignored.
// - Mode 11: low select is driven as the serial ROM's active-low select.
// - Mode 11: the shared clock/select pin drives the ROM serial clock.
// - Address pin low picks the index register, high the data buffer.
// - A read needs read strobe low, write strobe high and the chip selected.
// - A write needs write strobe low, read strobe high and the chip selected.
// - The external interrupt is edge or level triggered, of either polarity.
// - The interrupt output floats when idle and pulls low on an enabled event.
// - The interrupt output works only in parallel-bus and slave serial modes.
// - The converter takes the alternate analog input when its select bit is set.
// - The data bus keeps the level of its last accepted read or write when nobody drives it.
// - Wait pulls low on a converter read during conversion until it ends.
module sensor_host_pin_function_mux #(
  parameter int ROM_BITS    = 32,
  parameter int ROM_CLK_DIV = 4
) (
  input  logic                clk,
  input  logic                reset,
  input  logic                linkClk,
  input  logic                interfaceSelectHigh,
  input  logic                interfaceSelectLow,
  input  logic                sharedLowSelectIn,
  output logic                sharedLowSelectOut,
  output logic                sharedLowSelectOe,
  input  logic                sharedHighSelectOrSerialClockIn,
  output logic                sharedHighSelectOrSerialClockOut,
  output logic                sharedHighSelectOrSerialClockOe,
  input  logic                indexDataSelect,
  input  logic                readStrobeN,
  input  logic                writeStrobeN,
  input  logic [7:0]          dataIn,
  output logic [7:0]          dataOut,
  output logic                dataOe,
  output logic [7:0]          dataKeep,
  input  logic                masterOutIn,
  output logic                masterOutOut,
  output logic                masterOutOe,
  input  logic                serialInToMaster,
  input  logic                externalInterruptIn,
  output logic                interruptOutN,
  output logic                interruptOutOe,
  output logic                waitOutN,
  output logic                waitOutOe,
  output logic [7:0]          regIndex,
  output logic [7:0]          regWriteData,
  output logic                regWriteValid,
  output logic                regReadValid,
  input  logic [7:0]          regReadData,
  input  logic                intEdgeMode,
  input  logic                intActiveHigh,
  input  logic                intEnable,
  input  logic                intClear,
  input  logic                internalEvent,
  input  logic                analogInputSelectBit,
  output logic                converterInputSelect,
  input  logic                converterRead,
  input  logic                converterBusy,
  input  logic                romStart,
  input  logic [ROM_BITS-1:0] romTxWord,
  output logic [ROM_BITS-1:0] romRxWord,
  output logic                romBusy,
  output logic                romDone,
  output logic                spiByteValid,
  output logic [7:0]          spiByte,
  output logic [1:0]          currentMode
);
`include "pin_mux_defines.svh"

  localparam int BCW = $clog2(ROM_BITS + 1);
  localparam int DVW = (ROM_CLK_DIV > 2) ? $clog2(ROM_CLK_DIV) : 1;
  localparam int SW  = 18;

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------
  link_if lnk ();

  logic [SW-1:0] syncBundle;
  logic [1:0]    modeS;
  logic          lowSelS;
  logic          highSelS;
  logic          readNS;
  logic          writeNS;
  logic          addrS;
  logic [7:0]    dataS;
  logic          extS;
  logic          misoS;
  logic          toggleS;

  bit_sync #(
    .WIDTH (SW)
  ) uSync (
    .clk     (clk),
    .reset   (reset),
    .asyncIn ({interfaceSelectHigh, interfaceSelectLow, sharedLowSelectIn,
               sharedHighSelectOrSerialClockIn, readStrobeN, writeStrobeN,
               indexDataSelect, dataIn, externalInterruptIn,
               serialInToMaster, lnk.rxToggle}),
    .syncOut (syncBundle)
  );

  assign {modeS, lowSelS, highSelS, readNS, writeNS, addrS, dataS, extS,
          misoS, toggleS} = syncBundle;

  // The slave serial front runs on the master's clock.
  serial_link_front uFront (
    .linkClk      (linkClk),
    .reset        (reset),
    .slaveSelectN (sharedLowSelectIn),
    .serialIn     (masterOutIn),
    .lnk          (lnk.front)
  );

  // -----------------------------------------------------------------
  // State
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]                settle;
    logic                      captured;
    logic [1:0]                mode;
    logic                      rdActive;
    logic                      wrActive;
    logic                      wrAddr;
    logic [7:0]                wrData;
    logic [7:0]                index;
    logic [7:0]                readData;
    logic [7:0]                keep;
    logic                      regWrite;
    logic [7:0]                writeData;
    logic                      regRead;
    logic                      extPrev;
    logic                      intPending;
    logic                      intOut;
    logic                      waitActive;
    logic                      analogSel;
    pin_mux_pkg::rom_state_t   romState;
    logic [DVW-1:0]            divCnt;
    logic [BCW-1:0]            bitCnt;
    logic                      romSclk;
    logic [ROM_BITS-1:0]       romShiftOut;
    logic [ROM_BITS-1:0]       romShiftIn;
    logic [ROM_BITS-1:0]       romRx;
    logic                      romDonePulse;
    logic                      togglePrev;
    logic                      spiValid;
    logic [7:0]                spiData;
  } core_state_t;

  core_state_t s;
  core_state_t next_s;

  logic isParallel;
  logic isSlave;
  logic isRomMaster;
  logic chipSelected;
  logic readCombo;
  logic writeCombo;
  logic extActive;
  logic divTick;

  // Until the mode is caught every interface counts as unselected.
  assign isParallel  = s.captured && (s.mode == `MODE_PARALLEL);
  assign isSlave     = s.captured && (s.mode == `MODE_SPI_SLAVE);
  assign isRomMaster = s.captured && (s.mode == `MODE_USB_EXTERNAL);

  assign chipSelected = isParallel && !lowSelS && highSelS;
  assign readCombo    = chipSelected && !readNS && writeNS;
  assign writeCombo   = chipSelected && readNS && !writeNS;

  // Polarity is folded in before the edge detector sees the level.
  assign extActive = intActiveHigh ? extS : !extS;
  assign divTick   = (s.divCnt == DVW'(ROM_CLK_DIV - 1));

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    next_s              = s;
    next_s.regWrite     = 1'b0;
    next_s.regRead      = 1'b0;
    next_s.romDonePulse = 1'b0;
    next_s.spiValid     = 1'b0;

    // Mode pins are sampled once, after the synchronisers have filled.
    if (!s.captured) begin
      if (s.settle == `SETTLE_COUNT) begin
        next_s.captured = 1'b1;
        next_s.mode     = modeS;
      end else begin
        next_s.settle = s.settle + 2'h1;
      end
    end

    // Parallel read: data is captured when the strobe combination opens.
    next_s.rdActive = readCombo;
    if (readCombo && !s.rdActive) begin
      next_s.readData = addrS ? regReadData : s.index;
      next_s.regRead  = addrS;
    end

    // Parallel write: the value is taken on the closing edge of the strobe.
    next_s.wrActive = writeCombo;
    if (writeCombo) begin
      next_s.wrAddr = addrS;
      next_s.wrData = dataS;
    end else if (s.wrActive) begin
      if (s.wrAddr) begin
        next_s.regWrite  = 1'b1;
        next_s.writeData = s.wrData;
      end else begin
        next_s.index = s.wrData;
      end
    end

    // The keeper follows the data of the last parallel read or accepted write on the bus.
    if (s.rdActive) begin
      next_s.keep = s.readData;
    end else if (s.wrActive) begin
      next_s.keep = s.wrData;
    end

    // A new edge wins over a clear in the same cycle.
    next_s.extPrev    = extActive;
    next_s.intPending = (intEdgeMode && extActive && !s.extPrev) ||
                        (s.intPending && !intClear);
    next_s.intOut     = intEnable && (isParallel || isSlave) &&
                        ((intEdgeMode ? s.intPending : extActive) ||
                         internalEvent);

    // Wait holds until the conversion in progress finishes.
    next_s.waitActive = converterBusy && (s.waitActive || converterRead);
    next_s.analogSel  = analogInputSelectBit;

    // Slave serial bytes are ignored outside slave mode.
    next_s.togglePrev = toggleS;
    if (toggleS != s.togglePrev && isSlave) begin
      next_s.spiValid = 1'b1;
      next_s.spiData  = lnk.rxByte;
    end

    // Serial ROM master: clock idles low, data changes on falling edges.
    unique case (s.romState)
      pin_mux_pkg::ROM_IDLE: begin
        next_s.divCnt  = '0;
        next_s.bitCnt  = '0;
        next_s.romSclk = 1'b0;
        if (romStart && isRomMaster) begin
          next_s.romState    = pin_mux_pkg::ROM_SHIFT;
          next_s.romShiftOut = romTxWord;
        end
      end
      pin_mux_pkg::ROM_SHIFT: begin
        next_s.divCnt = divTick ? '0 : s.divCnt + 1'b1;
        if (divTick) begin
          next_s.romSclk = !s.romSclk;
          if (!s.romSclk) begin
            next_s.romShiftIn = {s.romShiftIn[ROM_BITS-2:0], misoS};
            next_s.bitCnt     = s.bitCnt + 1'b1;
          end else if (s.bitCnt == BCW'(ROM_BITS)) begin
            next_s.romState     = pin_mux_pkg::ROM_IDLE;
            next_s.romRx        = s.romShiftIn;
            next_s.romDonePulse = 1'b1;
          end else begin
            next_s.romShiftOut = {s.romShiftOut[ROM_BITS-2:0], 1'b0};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s          <= '0;
      s.romState <= pin_mux_pkg::ROM_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // -----------------------------------------------------------------
  // Pin drivers
  // -----------------------------------------------------------------
  // Shared select pins are inputs in modes 00 and 01 and unused in 10.
  assign sharedLowSelectOe  = isRomMaster;
  assign sharedLowSelectOut = !(s.romState == pin_mux_pkg::ROM_SHIFT);
  assign sharedHighSelectOrSerialClockOe  = isRomMaster;
  assign sharedHighSelectOrSerialClockOut = s.romSclk;

  // The ROM data line floats when idle; an external pull-up holds it.
  assign masterOutOe  = isRomMaster && (s.romState == pin_mux_pkg::ROM_SHIFT);
  assign masterOutOut = s.romShiftOut[ROM_BITS-1];

  assign dataOe   = s.rdActive;
  assign dataOut  = s.readData;
  assign dataKeep = s.keep;

  // Open-drain status outputs: only ever driven low.
  assign interruptOutN  = 1'b0;
  assign interruptOutOe = s.intOut;
  assign waitOutN       = 1'b0;
  assign waitOutOe      = s.waitActive;

  assign regIndex             = s.index;
  assign regWriteData         = s.writeData;
  assign regWriteValid        = s.regWrite;
  assign regReadValid         = s.regRead;
  assign converterInputSelect = s.analogSel;
  assign romRxWord            = s.romRx;
  assign romBusy              = (s.romState == pin_mux_pkg::ROM_SHIFT);
  assign romDone              = s.romDonePulse;
  assign spiByteValid         = s.spiValid;
  assign spiByte              = s.spiData;
  assign currentMode          = s.mode;

endmodule // sensor_host_pin_function_mux

// file: tb/sensor_host_pin_function_mux_sva.sv
// Purpose: Port-level checks of the sensor pin function block.
// Assumes: Sees only the top module's ports.
// Notes:   Bound below.
`timescale 1ns/100ps
`include "pin_mux_defines.svh"
module sensor_host_pin_function_mux_sva (
  input logic       clk,
  input logic       reset,
  input logic       sharedLowSelectOut,
  input logic       sharedLowSelectOe,
  input logic       sharedHighSelectOrSerialClockOe,
  input logic       masterOutOe,
  input logic       dataOe,
  input logic       regWriteValid,
  input logic       spiByteValid,
  input logic       interruptOutOe,
  input logic       intEnable,
  input logic       waitOutOe,
  input logic       converterRead,
  input logic       converterBusy,
  input logic       analogInputSelectBit,
  input logic       converterInputSelect,
  input logic       romStart,
  input logic       romBusy,
  input logic       romDone,
  input logic [1:0] currentMode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_low_oe;
    sharedLowSelectOe |-> currentMode == `MODE_USB_EXTERNAL;
  endproperty
  a_low_oe: assert property (p_low_oe) else $error("low oe outside rom");
  property p_clk_oe;
    sharedHighSelectOrSerialClockOe |-> currentMode == `MODE_USB_EXTERNAL;
  endproperty
  a_clk_oe: assert property (p_clk_oe) else $error("clk oe outside rom");
  property p_rom_sel;
    romBusy |-> !sharedLowSelectOut && sharedLowSelectOe && masterOutOe;
  endproperty
  a_rom_sel: assert property (p_rom_sel) else $error("rom select not low");
  property p_rom_start;
    romStart && !romBusy && !romDone && sharedLowSelectOe |=> romBusy [*4];
  endproperty
  a_rom_start: assert property (p_rom_start) else $error("rom start lost");
  property p_data_oe;
    dataOe |-> currentMode == `MODE_PARALLEL;
  endproperty
  a_data_oe: assert property (p_data_oe) else $error("data oe outside bus");
  property p_write;
    regWriteValid |-> currentMode == `MODE_PARALLEL;
  endproperty
  a_write: assert property (p_write) else $error("write outside bus");
  property p_byte;
    spiByteValid |-> currentMode == `MODE_SPI_SLAVE;
  endproperty
  a_byte: assert property (p_byte) else $error("byte outside slave mode");
  property p_int_mode;
    interruptOutOe |-> currentMode inside {`MODE_PARALLEL, `MODE_SPI_SLAVE};
  endproperty
  a_int_mode: assert property (p_int_mode) else $error("int in usb mode");
  property p_int_en;
    !intEnable [*3] |-> !interruptOutOe;
  endproperty
  a_int_en: assert property (p_int_en) else $error("int while disabled");
  property p_wait_set;
    converterRead && converterBusy |=> waitOutOe;
  endproperty
  a_wait_set: assert property (p_wait_set) else $error("wait not raised");
  property p_wait_end;
    $fell(converterBusy) |=> !waitOutOe;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("wait not released");
  property p_analog;
    $changed(analogInputSelectBit) |=> converterInputSelect == $past(analogInputSelectBit);
  endproperty
  a_analog: assert property (p_analog) else $error("analog select lost");
endmodule // sensor_host_pin_function_mux_sva

bind sensor_host_pin_function_mux sensor_host_pin_function_mux_sva chk (.*);

// file: tb/serial_rom_model.sv
// Purpose: Serial ROM on the far side of the master serial port.
// Assumes: Clock idles low; bits move most significant first.
// Notes:   Output changes a little after each falling clock edge.
`timescale 1ns/100ps
module serial_rom_model #(
  parameter int           W     = 8,
  parameter logic [W-1:0] REPLY = 8'h3C
) (
  input  wire logic    selectN,
  input  wire logic    sclk,
  input  wire logic    mosi,
  output logic         miso,
  output logic [W-1:0] got
);
  logic [W-1:0] sh;
  initial miso = 1'b1;
  initial got = '0;
  // The output delay keeps the master from sampling a bit that is still moving.
  always @(negedge selectN) begin
    sh = REPLY;
    #5 miso = sh[W-1];
  end
  always @(posedge sclk) begin
    if (!selectN) got = {got[W-2:0], mosi};
  end
  always @(negedge sclk) begin
    if (!selectN) begin
      sh = sh << 1;
      #5 miso = sh[W-1];
    end
  end
  // A released line must not keep showing the last bit.
  always @(posedge selectN) miso = ~miso;
endmodule // serial_rom_model

// file: tb/sensor_host_pin_function_mux_bench.sv
// Purpose: Self-checking bench of the sensor pin function block.
// Assumes: Inputs other than the serial pins change on the falling clock edge.
// Notes:   Each mode needs its own reset, since the mode is caught once.
`timescale 1ns/100ps
`include "pin_mux_defines.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %0t got %0h want %0h", $time, g, e); end end
module sensor_host_pin_function_mux_bench;
  localparam int RB = 8;
  typedef struct packed {logic rd; logic a; logic [7:0] d; logic [7:0] exp;} row_t;
  logic       clk, reset, linkClk, interfaceSelectHigh, interfaceSelectLow;
  logic       sharedLowSelectIn, sharedLowSelectOut, sharedLowSelectOe;
  logic       sharedHighSelectOrSerialClockIn, sharedHighSelectOrSerialClockOut;
  logic       sharedHighSelectOrSerialClockOe, indexDataSelect, readStrobeN, writeStrobeN;
  logic       dataOe, masterOutIn, masterOutOut, masterOutOe, serialInToMaster;
  logic       externalInterruptIn, interruptOutN, interruptOutOe, waitOutN, waitOutOe;
  logic       regWriteValid, regReadValid, intEdgeMode, intActiveHigh, intEnable, intClear;
  logic       internalEvent, analogInputSelectBit, converterInputSelect, converterRead;
  logic       converterBusy, romStart, romBusy, romDone, spiByteValid;
  logic       lowDrv, highDrv, mosiDrv, busDrv;
  logic [7:0] dataIn, dataOut, dataKeep, regIndex, regWriteData, regReadData, spiByte, busVal;
  logic [RB-1:0] romTxWord, romRxWord, romGot;
  logic [1:0] currentMode;
  logic [7:0] bytes [$];
  int         num_errors, checks, rdPulses, wrPulses;
  row_t       rows [7] = '{'{0, 0, 8'h5A, 8'h5A}, '{1, 0, 8'h00, 8'h5A}, '{0, 1, 8'hC3, 8'hC3},
                           '{1, 1, 8'h00, 8'hA5}, '{0, 0, 8'hFF, 8'hFF}, '{1, 0, 8'h00, 8'hFF},
                           '{1, 1, 8'h00, 8'h00}};
  logic [3:0] bad [4] = '{4'b0100, 4'b0010, 4'b1110, 4'b0001};

  // -----------------------------------------------------------------
  // Pins and partner
  // -----------------------------------------------------------------
  assign sharedLowSelectIn = sharedLowSelectOe ? sharedLowSelectOut : lowDrv;
  assign sharedHighSelectOrSerialClockIn =
    sharedHighSelectOrSerialClockOe ? sharedHighSelectOrSerialClockOut : highDrv;
  assign linkClk = sharedHighSelectOrSerialClockIn;
  assign masterOutIn = masterOutOe ? masterOutOut : mosiDrv;
  assign dataIn = dataOe ? dataOut : (busDrv ? busVal : dataKeep);
  assign regReadData = ~regIndex;

  sensor_host_pin_function_mux #(.ROM_BITS(RB), .ROM_CLK_DIV(4)) dut (.*);
  serial_rom_model #(.W(RB), .REPLY(8'h3C)) rom (.selectN(sharedLowSelectIn),
    .sclk(sharedHighSelectOrSerialClockIn), .mosi(masterOutIn), .miso(serialInToMaster),
    .got(romGot));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (regReadValid === 1'b1) rdPulses++;
    if (regWriteValid === 1'b1) wrPulses++;
    if (spiByteValid === 1'b1) bytes.push_back(spiByte);
  end

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic tally_and_finish();
    if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic doReset(input logic [1:0] m);
    @(negedge clk);
    {interfaceSelectHigh, interfaceSelectLow} = m;
    reset = 1'b1;
    repeat (12) @(negedge clk);
    reset = 1'b0;
    repeat (8) @(negedge clk);
    `CHK(currentMode, m)
    {interfaceSelectHigh, interfaceSelectLow} = ~m;
    repeat (6) @(negedge clk);
    `CHK(currentMode, m)
  endtask
  task automatic busOp(input logic rd, input logic a, input logic [7:0] d, input logic [7:0] e);
    @(negedge clk);
    indexDataSelect = a;
    busVal = d;
    busDrv = !rd;
    readStrobeN = !rd;
    writeStrobeN = rd;
    repeat (5) @(negedge clk);
    if (rd) `CHK({dataOe, dataOut}, {1'b1, e})
    {readStrobeN, writeStrobeN} = 2'b11;
    repeat (5) @(negedge clk);
    busDrv = 1'b0;
    `CHK(dataOe, 1'b0)
    `CHK(dataKeep, e)
  endtask
  task automatic refused(input logic [3:0] p);
    logic [7:0] ix = regIndex;
    int         w = wrPulses;
    indexDataSelect = 1'b0;
    busVal = 8'h77;
    busDrv = 1'b1;
    {lowDrv, highDrv, readStrobeN, writeStrobeN} = p;
    repeat (6) @(negedge clk);
    `CHK(dataOe, 1'b0)
    {readStrobeN, writeStrobeN} = 2'b11;
    repeat (5) @(negedge clk);
    busDrv = 1'b0;
    `CHK(regIndex, ix)
    `CHK(wrPulses - w, 0)
  endtask
  task automatic ie(input logic [3:0] s, input logic want);
    {intEdgeMode, intActiveHigh, intEnable, externalInterruptIn} = s;
    repeat (5) @(negedge clk);
    `CHK(interruptOutOe, want)
  endtask
  task automatic intSuite(input logic on);
    ie(4'b0010, on);
    ie(4'b0011, 1'b0);
    ie(4'b0111, on);
    ie(4'b0101, 1'b0);
    intClear = 1'b1;
    ie(4'b1110, 1'b0);
    intClear = 1'b0;
    ie(4'b1111, on);
    ie(4'b1110, on);
    intClear = 1'b1;
    ie(4'b1110, 1'b0);
    intClear = 1'b0;
    internalEvent = 1'b1;
    ie(4'b0011, on);
    internalEvent = 1'b0;
    `CHK(interruptOutN, 1'b0)
  endtask
  // The serial clock only runs inside a frame, at a phase unrelated to clk.
  task automatic spiSend(input logic [15:0] b, input int n);
    @(negedge clk);
    #7 lowDrv = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      mosiDrv = b[i];
      #15 highDrv = 1'b1;
      #15 highDrv = 1'b0;
    end
    #15 lowDrv = 1'b1;
    mosiDrv = ~mosiDrv;
    repeat (8) @(negedge clk);
  endtask

  // -----------------------------------------------------------------
  // Sequence
  // -----------------------------------------------------------------
  initial begin
    {interfaceSelectHigh, interfaceSelectLow, indexDataSelect, busDrv, busVal, intClear} = '0;
    {externalInterruptIn, intEdgeMode, intActiveHigh, intEnable, internalEvent} = '0;
    {analogInputSelectBit, converterRead, converterBusy, romStart, romTxWord, highDrv} = '0;
    {reset, lowDrv, mosiDrv, readStrobeN, writeStrobeN} = '1;
    doReset(`MODE_PARALLEL);
    {lowDrv, highDrv} = 2'b01;
    foreach (rows[i]) begin
      automatic int w0 = wrPulses;
      automatic int r0 = rdPulses;
      busOp(rows[i].rd, rows[i].a, rows[i].d, rows[i].exp);
      `CHK(wrPulses - w0, (!rows[i].rd && rows[i].a) ? 1 : 0)
      `CHK(rdPulses - r0, (rows[i].rd && rows[i].a) ? 1 : 0)
      if (!rows[i].rd) `CHK(rows[i].a ? regWriteData : regIndex, rows[i].d)
    end
    foreach (bad[i]) refused(bad[i]);
    intSuite(1'b1);
    converterBusy = 1'b1;
    converterRead = 1'b1;
    @(negedge clk);
    converterRead = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(waitOutOe, 1'b1)
    converterBusy = 1'b0;
    repeat (2) @(negedge clk);
    `CHK(waitOutOe, 1'b0)
    analogInputSelectBit = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(converterInputSelect, 1'b1)
    romStart = 1'b1;
    @(negedge clk);
    romStart = 1'b0;
    repeat (3) @(negedge clk);
    `CHK({romBusy, sharedLowSelectOe}, 2'b00)

    doReset(`MODE_SPI_SLAVE);
    {lowDrv, highDrv} = 2'b10;
    spiSend(16'h813C, 16);
    spiSend(16'hF000, 4);
    spiSend(16'h5A00, 8);
    `CHK(bytes.size(), 3)
    foreach (bytes[i]) `CHK(bytes[i], i == 0 ? 8'h81 : i == 1 ? 8'h3C : 8'h5A)
    refused(4'b0101);
    {lowDrv, highDrv} = 2'b10;
    intSuite(1'b1);

    doReset(`MODE_USB_INTERNAL);
    spiSend(16'hFFFF, 8);
    `CHK(bytes.size(), 3)
    refused(4'b0110);
    refused(4'b0101);
    intSuite(1'b0);

    doReset(`MODE_USB_EXTERNAL);
    {lowDrv, highDrv} = 2'b11;
    romTxWord = 8'hA5;
    romStart = 1'b1;
    @(negedge clk);
    romStart = 1'b0;
    `CHK({romBusy, sharedLowSelectIn, sharedHighSelectOrSerialClockOe}, 3'b101)
    for (int i = 0; i < 200 && romDone !== 1'b1; i++) @(negedge clk);
    `CHK(romRxWord, 8'h3C)
    `CHK(romGot, 8'hA5)
    repeat (2) @(negedge clk);
    `CHK({romBusy, sharedLowSelectIn}, 2'b01)
    intSuite(1'b0);
    tally_and_finish();
  end

  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
endmodule // sensor_host_pin_function_mux_bench
